/* hdl/dbg_pkg.sv */
// shared constants for the debug mode controller
package dbg_pkg;
  localparam int TRACE_DEPTH = 10;
  localparam int TRACE_AW    = 4;
  localparam int SCAN_W      = 16;
  localparam int PC_W        = 16;
  localparam int BP_W        = 16;
  localparam int COND_N      = 4;
  localparam int CLK_HZ      = 20000000;
  localparam int STEP_TICK_MS = 100;
  // cycles of timer advance per stepped scan, rounded down (a longest time)
  localparam longint STEP_TICK_CYC = longint'(CLK_HZ) * STEP_TICK_MS / 1000;
  // stop cause codes
  localparam logic [2:0] CAUSE_NONE  = 3'h0;
  localparam logic [2:0] CAUSE_BREAK = 3'h1;
  localparam logic [2:0] CAUSE_STEP  = 3'h2;
  localparam logic [2:0] CAUSE_RUNG  = 3'h3;
  localparam logic [2:0] CAUSE_NSCAN = 3'h4;
  localparam logic [2:0] CAUSE_COND  = 3'h5;
  // reported mode identities
  localparam logic [2:0] MODE_HALT   = 3'h0;
  localparam logic [2:0] MODE_DHALT  = 3'h1;
  localparam logic [2:0] MODE_DRUN   = 3'h2;
  localparam logic [2:0] MODE_DSTOP  = 3'h3;
  localparam logic [2:0] MODE_SHALT  = 3'h5;
  localparam logic [2:0] MODE_SRUN   = 3'h6;
  localparam logic [2:0] MODE_SSTOP  = 3'h7;
  // run function select
  localparam logic [1:0] FN_FREE = 2'h0;
  localparam logic [1:0] FN_STEP = 2'h1;
  localparam logic [1:0] FN_RUNG = 2'h2;
  localparam logic [PC_W-1:0] PC_TOP = 16'h0000;
  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_HALT = 4'h2,
    ST_RUN  = 4'h4,
    ST_STOP = 4'h8
  } dstate_t;
endpackage

/* hdl/trace_mem.sv */
`timescale 1ns/1ps
// small trace history memory with registered read data
module trace_mem #(
  parameter int DEPTH = 10,
  parameter int AW    = 4,
  parameter int DW    = 16
) (
  // clock
  input  wire logic          clk,
  input  wire logic          ce,
  // write side
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // read side
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [DEPTH];

  // write port plus registered read
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule // trace_mem

/* hdl/program_debug_mode_controller.sv */
`timescale 1ns/1ps
// debug mode sub-mode machine and run control for the scan controller
// Notes on behaviour
// - debug entry accepted only from halted mode; enters debug-halted.
// - debug-halted allows configuration and forces all outputs off.
// - running pauses when stop condition met; paused holds outputs.
// - cause of each running-to-paused transition is recorded for readback.
// - isolation stops input sampling and output forwarding.
// - isolation reports isolated sub-mode identities.
// - last 10 scans of trace kept during runs, not when stepping.
// - one breakpoint with hit count; zero disables it.
// - initial start reinitialises and starts top; continue resumes.
// - launch from debug-halted always forces initial start.
// - step from halted pauses at top; from paused executes one.
// - taken call or branch makes its target the next pause point; rung step never pauses at a taken target.
// - counted loop runs fully then pauses after the loop.
// - interrupts still run while stepping but are not traced.
// - rung step pauses at next rung start, not inside calls.
// - scan count 0 disables; otherwise run that many scans then pause.
// - AND/OR of four conditions checked at end of scan or breakpoint.
// - no initial load on debug-halted to running transition.
// - timers normal when free running; 100 ms per scan when stepping.
// - sub-programs not interrupted while stepping.
// - interrupts inhibited halted, pending paused, enabled running.
module program_debug_mode_controller #(
  parameter int SCAN_W = dbg_pkg::SCAN_W,
  parameter int PC_W   = dbg_pkg::PC_W,
  parameter int BP_W   = dbg_pkg::BP_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // terminal commands (one-cycle pulses)
  input  wire logic              cmdEnter,
  input  wire logic              cmdExit,
  input  wire logic              cmdStart,
  input  wire logic              startContinue,
  input  wire logic [1:0]        runFunc,
  // execution conditions
  input  wire logic              isolateIo,
  input  wire logic [BP_W-1:0]   bpCount,
  input  wire logic [PC_W-1:0]   bpAddr,
  input  wire logic [SCAN_W-1:0] scanCount,
  input  wire logic              condEnable,
  input  wire logic              condOr,
  input  wire logic              condAtBreak,
  input  wire logic [3:0]        condTerms,
  // execution engine status
  input  wire logic              hostHalted,
  input  wire logic              instrFetch,
  input  wire logic [PC_W-1:0]   fetchPc,
  input  wire logic              scanEnd,
  input  wire logic              rungStart,
  input  wire logic              takenTarget,
  input  wire logic              inLoop,
  input  wire logic              inSubroutine,
  input  wire logic              inInterrupt,
  // execution engine control
  output logic                   debugActive,
  output logic                   execEnable,
  output logic                   initUserData,
  output logic                   initialLoad,
  output logic [PC_W-1:0]        startPc,
  output logic                   startPulse,
  output logic                   subprogInterruptEn,
  output logic                   timerStepMode,
  output logic                   timerStepTick,
  output logic                   intInhibit,
  output logic                   intPending,
  // i/o gating
  input  wire logic [15:0]       extInputs,
  output logic [15:0]            input_points,
  input  wire logic [15:0]       output_points,
  output logic [15:0]            outModules,
  // status readback
  output logic [2:0]             modeId,
  output logic [2:0]             stopCause,
  input  wire logic [3:0]        traceRdAddr,
  output logic [PC_W-1:0]        traceRdData
);
  dbg_pkg::dstate_t state_r, state_nxt;
  logic [2:0]        cause_r;
  logic [BP_W-1:0]   bpHits_r;
  logic [SCAN_W-1:0] scans_r;
  logic [PC_W-1:0]   resumePc_r;
  logic [1:0]        func_r;
  logic [3:0]        trPtr_r;
  logic [15:0]       outHold_r;
  logic              halted, running, paused, stepping;
  logic              bpHit, bpStop, nscanStop, condMet, condStop, stepStop, rungStop;
  logic              stopNow, launch, exitNow;
  logic              skipFirst_r;
  logic [2:0]        causeNxt;

  function automatic logic comb4(input logic [3:0] t, input logic orMode);
    comb4 = orMode ? |t : &t;
  endfunction

  assign halted   = state_r == dbg_pkg::ST_HALT;
  assign running  = state_r == dbg_pkg::ST_RUN;
  assign paused   = state_r == dbg_pkg::ST_STOP;
  assign stepping = func_r != dbg_pkg::FN_FREE;

  // stop sources; a loop body never pauses a step or rung, a taken target only never pauses a rung
  assign bpHit     = running && instrFetch && fetchPc == bpAddr && bpCount != '0;
  assign bpStop    = bpHit && bpHits_r + BP_W'(1) == bpCount;
  assign nscanStop = running && scanEnd && scanCount != '0
                     && scans_r + SCAN_W'(1) == scanCount;
  assign condMet   = condEnable && comb4(condTerms, condOr);
  assign condStop  = running && condMet && (condAtBreak ? bpHit : scanEnd);
  // step pauses at next fetched instruction, following taken targets
  assign stepStop  = running && func_r == dbg_pkg::FN_STEP && instrFetch
                     && !inLoop && !inInterrupt && !skipFirst_r;
  // rung pauses only at top-level rung starts
  assign rungStop  = running && func_r == dbg_pkg::FN_RUNG && rungStart && !skipFirst_r
                     && !inSubroutine && !inLoop && !inInterrupt && !takenTarget;
  assign stopNow   = bpStop || nscanStop || condStop || stepStop || rungStop;
  assign launch    = cmdStart && (halted || paused);
  assign exitNow   = cmdExit && state_r != dbg_pkg::ST_OFF;

  // cause priority: breakpoint, condition, scans, step kind
  assign causeNxt = bpStop    ? dbg_pkg::CAUSE_BREAK :
                    condStop  ? dbg_pkg::CAUSE_COND  :
                    nscanStop ? dbg_pkg::CAUSE_NSCAN :
                    stepStop  ? dbg_pkg::CAUSE_STEP  : dbg_pkg::CAUSE_RUNG;

  // sub-mode machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dbg_pkg::ST_OFF:  if (cmdEnter && hostHalted) state_nxt = dbg_pkg::ST_HALT;
      dbg_pkg::ST_HALT: if (exitNow) state_nxt = dbg_pkg::ST_OFF;
                        else if (launch) state_nxt = dbg_pkg::ST_RUN;
      dbg_pkg::ST_RUN:  if (exitNow) state_nxt = dbg_pkg::ST_OFF;
                        else if (stopNow) state_nxt = dbg_pkg::ST_STOP;
      dbg_pkg::ST_STOP: if (exitNow) state_nxt = dbg_pkg::ST_OFF;
                        else if (launch) state_nxt = dbg_pkg::ST_RUN;
      default:          state_nxt = dbg_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= dbg_pkg::ST_OFF;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // stop cause register, cleared on exit
  always_ff @(posedge clk) begin
    if (rst || (ce && exitNow)) begin
      cause_r <= dbg_pkg::CAUSE_NONE;
    end else if (ce && running && stopNow) begin
      cause_r <= causeNxt;
    end
  end

  // latched run function and resume point
  always_ff @(posedge clk) begin
    if (rst) begin
      func_r     <= dbg_pkg::FN_FREE;
      resumePc_r <= dbg_pkg::PC_TOP;
    end else if (ce) begin
      if (launch) func_r <= runFunc;
      if (running && stopNow) resumePc_r <= fetchPc;
    end
  end

  // a resume re-fetches the paused instruction first; it must run, not pause again
  always_ff @(posedge clk) begin
    if (rst) begin
      skipFirst_r <= 1'b0;
    end else if (ce) begin
      if (launch) skipFirst_r <= paused;
      else if (running && instrFetch) skipFirst_r <= 1'b0;
    end
  end

  // breakpoint hit and scan counters restart at each launch
  always_ff @(posedge clk) begin
    if (rst || (ce && launch)) begin
      bpHits_r <= '0;
      scans_r  <= '0;
    end else if (ce) begin
      if (bpHit) bpHits_r <= bpHits_r + BP_W'(1);
      if (running && scanEnd) scans_r <= scans_r + SCAN_W'(1);
    end
  end

  // launch controls; halted launch is always initial start
  logic initStart;
  assign initStart = halted || !startContinue;
  always_ff @(posedge clk) begin
    if (rst) begin
      startPulse   <= 1'b0;
      initUserData <= 1'b0;
      startPc      <= dbg_pkg::PC_TOP;
    end else if (ce) begin
      startPulse   <= launch;
      initUserData <= launch && initStart;
      if (launch) startPc <= initStart ? dbg_pkg::PC_TOP : resumePc_r;
    end
  end
  assign initialLoad = 1'b0; // never reloaded from debug-halted

  // step timer tick: one fixed advance per stepped scan
  always_ff @(posedge clk) begin
    if (rst) begin
      timerStepTick <= 1'b0;
    end else if (ce) begin
      timerStepTick <= running && stepping && scanEnd;
    end
  end
  assign timerStepMode      = debugActive && stepping;
  assign subprogInterruptEn = !(debugActive && stepping);

  // interrupt gating per sub-mode
  always_ff @(posedge clk) begin
    if (rst || (ce && (exitNow || running))) begin
      intPending <= 1'b0;
    end else if (ce && paused) begin
      intPending <= 1'b1;
    end
  end
  assign intInhibit  = halted;
  assign debugActive = state_r != dbg_pkg::ST_OFF;
  assign execEnable  = running;

  // output hold: off in halted, held in paused
  always_ff @(posedge clk) begin
    if (rst) begin
      outHold_r <= '0;
    end else if (ce && !paused) begin
      outHold_r <= output_points;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      outModules   <= '0;
      input_points <= '0;
    end else if (ce) begin
      if (halted) outModules <= '0;
      else if (!(debugActive && isolateIo)) outModules <= paused ? outHold_r : output_points;
      if (!(debugActive && isolateIo)) input_points <= extInputs;
    end
  end

  // reported mode identity
  always_comb begin
    case (state_r)
      dbg_pkg::ST_HALT: modeId = isolateIo ? dbg_pkg::MODE_SHALT : dbg_pkg::MODE_DHALT;
      dbg_pkg::ST_RUN:  modeId = isolateIo ? dbg_pkg::MODE_SRUN  : dbg_pkg::MODE_DRUN;
      dbg_pkg::ST_STOP: modeId = isolateIo ? dbg_pkg::MODE_SSTOP : dbg_pkg::MODE_DSTOP;
      default:          modeId = dbg_pkg::MODE_HALT;
    endcase
  end
  assign stopCause = cause_r;

  // trace ring: free runs only, skipping interrupt code
  logic trWr;
  assign trWr = running && !stepping && scanEnd && !inInterrupt;
  always_ff @(posedge clk) begin
    if (rst) begin
      trPtr_r <= '0;
    end else if (ce && trWr) begin
      trPtr_r <= (trPtr_r == 4'(dbg_pkg::TRACE_DEPTH - 1)) ? 4'h0 : trPtr_r + 4'h1;
    end
  end
  trace_mem #(.DEPTH(dbg_pkg::TRACE_DEPTH), .AW(dbg_pkg::TRACE_AW), .DW(PC_W)) uTrace (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (trWr),
    .wrAddr (trPtr_r),
    .wrData (fetchPc),
    .rdAddr (traceRdAddr),
    .rdData (traceRdData)
  );

  // checks
  sequence s_launch; launch; endsequence
  entry_from_halt_a: assert property (@(posedge clk) disable iff (rst)
    ce && state_r == dbg_pkg::ST_OFF && !hostHalted |=> state_r == dbg_pkg::ST_OFF)
    else $error("debug entered while not halted");
  halted_outs_off_a: assert property (@(posedge clk) disable iff (rst)
    ce && halted |=> outModules == '0) else $error("outputs not off");
  stop_to_pause_a: assert property (@(posedge clk) disable iff (rst)
    ce && running && stopNow && !exitNow |=> paused) else $error("no pause on stop");
  cause_record_a: assert property (@(posedge clk) disable iff (rst)
    ce && running && bpStop && !exitNow |=> stopCause == dbg_pkg::CAUSE_BREAK)
    else $error("cause not recorded");
  isolated_mode_a: assert property (@(posedge clk) disable iff (rst)
    running && isolateIo |-> modeId == dbg_pkg::MODE_SRUN) else $error("bad mode id");
  halted_init_a: assert property (@(posedge clk) disable iff (rst)
    ce && halted and s_launch |=> initUserData && startPc == dbg_pkg::PC_TOP)
    else $error("no initial start");
  step_no_trace_a: assert property (@(posedge clk) disable iff (rst)
    ce && running && stepping |=> trPtr_r == $past(trPtr_r))
    else $error("trace while stepping");
  int_inhibit_a: assert property (@(posedge clk) disable iff (rst)
    halted |-> intInhibit && !execEnable) else $error("interrupt not inhibited");
  int_pending_a: assert property (@(posedge clk) disable iff (rst)
    ce && paused && !exitNow |=> intPending) else $error("interrupt not held pending");
  iso_inputs_a: assert property (@(posedge clk) disable iff (rst)
    ce && debugActive && isolateIo |=> input_points == $past(input_points))
    else $error("inputs sampled while isolated");
  exit_clears_a: assert property (@(posedge clk) disable iff (rst)
    ce && exitNow |=> state_r == dbg_pkg::ST_OFF && stopCause == dbg_pkg::CAUSE_NONE)
    else $error("exit failed");
endmodule // program_debug_mode_controller

/* test/engine_model.sv */
// execution engine stand-in that fetches a four-instruction scan
`timescale 1ns/1ps
module engine_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // run control from the block
  input  wire logic        execEnable,
  input  wire logic        startPulse,
  input  wire logic [15:0] startPc,
  // engine status to the block
  output logic             instrFetch,
  output logic [15:0]      fetchPc,
  output logic             scanEnd,
  output logic             rungStart
);
  logic        go;
  logic [15:0] pc_r;

  assign go = execEnable & ~startPulse & ~rst;

  // fixed program, never altered during debug; idle pc bus toggles so stale values show
  always_ff @(posedge clk) begin
    instrFetch <= go;
    scanEnd    <= go & (pc_r[1:0] == 2'h3);
    rungStart  <= go & ~pc_r[0];
    fetchPc    <= rst ? 16'h0000 : (execEnable ? pc_r : ~fetchPc);
    if (rst)
      pc_r <= 16'h0000;
    else if (startPulse)
      pc_r <= startPc;
    else if (execEnable)
      pc_r <= {14'h0000, pc_r[1:0] + 2'h1};
  end
endmodule // engine_model

/* test/program_debug_mode_controller_tb_top.sv */
// self-checking bench for the debug mode controller
`timescale 1ns/1ps
module program_debug_mode_controller_tb_top;
  logic        clk, rst, cmdEnter, cmdExit, cmdStart, startContinue, isolateIo;
  logic        hostHalted, condEnable, condOr, condAtBreak, instrFetch, scanEnd;
  logic        rungStart, debugActive, execEnable, initUserData, initialLoad;
  logic        startPulse, subprogInterruptEn, timerStepMode, timerStepTick;
  logic        intInhibit, intPending, inLoop, inSubroutine, inInterrupt, takenTarget;
  logic [1:0]  runFunc;
  logic [2:0]  modeId, stopCause;
  logic [3:0]  condTerms, traceRdAddr;
  logic [15:0] bpCount, bpAddr, scanCount, fetchPc, startPc, traceRdData, held;
  logic [15:0] extInputs, input_points, output_points, outModules;
  int          n_fail, n_compared, nScan, nHit;

  // nested-code flags are levels held by the bench around flagged runs
  program_debug_mode_controller u_dut (
    .clk, .rst, .ce(1'b1), .cmdEnter, .cmdExit, .cmdStart, .startContinue,
    .runFunc, .isolateIo, .bpCount, .bpAddr, .scanCount, .condEnable, .condOr,
    .condAtBreak, .condTerms, .hostHalted, .instrFetch, .fetchPc, .scanEnd,
    .rungStart, .takenTarget, .inLoop, .inSubroutine,
    .inInterrupt, .debugActive, .execEnable, .initUserData, .initialLoad,
    .startPc, .startPulse, .subprogInterruptEn, .timerStepMode, .timerStepTick,
    .intInhibit, .intPending, .extInputs, .input_points, .output_points,
    .outModules, .modeId, .stopCause, .traceRdAddr, .traceRdData
  );

  engine_model u_eng (
    .clk, .rst, .execEnable, .startPulse, .startPc, .instrFetch, .fetchPc,
    .scanEnd, .rungStart
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle command pulse: 0 enter, 1 start, 2 exit; returns with result settled
  task automatic cmd(input int k);
    @(posedge clk);
    cmdEnter <= (k == 0);
    cmdStart <= (k == 1);
    cmdExit  <= (k == 2);
    @(posedge clk);
    {cmdEnter, cmdStart, cmdExit} <= 3'h0;
    @(negedge clk);
  endtask

  // bounded wait for a mode, counting scan ends and breakpoint fetches seen while running unisolated (debug-running)
  task automatic wait_mode(input logic [2:0] m);
    nScan = 0;
    nHit = 0;
    for (int i = 0; i < 200 && modeId !== m; i++) begin
      @(negedge clk);
      if (modeId === dbg_pkg::MODE_DRUN && scanEnd === 1'b1)
        nScan++;
      if (modeId === dbg_pkg::MODE_DRUN && instrFetch === 1'b1 && fetchPc === bpAddr)
        nHit++;
    end
    if (modeId !== m) begin
      n_fail++;
      $display("Error modeId expected %h seen %h", m, modeId);
      finish_test();
    end
  endtask

  task automatic t_enter;
    cmd(0);
    chk("modeId refused", 16'(dbg_pkg::MODE_HALT), 16'(modeId));
    @(posedge clk);
    hostHalted <= 1'b1;
    cmd(0);
    chk("modeId", 16'(dbg_pkg::MODE_DHALT), 16'(modeId));
    @(negedge clk);
    chk("outModules", 16'h0000, outModules);
    chk("intInhibit", 16'h0001, 16'(intInhibit));
    $display("t_enter done");
  endtask

  task automatic t_step_iso;
    @(posedge clk);
    isolateIo <= 1'b1;
    runFunc <= dbg_pkg::FN_STEP;
    startContinue <= 1'b1;
    @(negedge clk);
    chk("modeId", 16'(dbg_pkg::MODE_SHALT), 16'(modeId));
    held = input_points;
    @(posedge clk);
    extInputs <= ~extInputs;
    cmd(1);
    chk("modeId", 16'(dbg_pkg::MODE_SRUN), 16'(modeId));
    chk("startPulse", 16'h0001, 16'(startPulse));
    chk("initUserData", 16'h0001, 16'(initUserData));
    chk("startPc", dbg_pkg::PC_TOP, startPc);
    chk("initialLoad", 16'h0000, 16'(initialLoad));
    chk("timerStepMode", 16'h0001, 16'(timerStepMode));
    chk("subprogInterruptEn", 16'h0000, 16'(subprogInterruptEn));
    chk("intInhibit", 16'h0000, 16'(intInhibit));
    wait_mode(dbg_pkg::MODE_SSTOP);
    chk("stopCause", 16'(dbg_pkg::CAUSE_STEP), 16'(stopCause));
    chk("input_points", held, input_points);
    @(posedge clk);
    isolateIo <= 1'b0;
    @(negedge clk);
    chk("modeId", 16'(dbg_pkg::MODE_DSTOP), 16'(modeId));
    cmd(1);
    chk("initUserData", 16'h0000, 16'(initUserData));
    wait_mode(dbg_pkg::MODE_DSTOP);
    chk("stopCause", 16'(dbg_pkg::CAUSE_STEP), 16'(stopCause));
    $display("t_step_iso done");
  endtask

  task automatic t_nscan;
    @(posedge clk);
    runFunc <= dbg_pkg::FN_FREE;
    scanCount <= 16'h0003;
    output_points <= 16'hA5A5;
    cmd(1);
    chk("initUserData", 16'h0000, 16'(initUserData));
    chk("startPc resume", 16'h0001, startPc);
    chk("timerStepMode", 16'h0000, 16'(timerStepMode));
    chk("subprogInterruptEn", 16'h0001, 16'(subprogInterruptEn));
    wait_mode(dbg_pkg::MODE_DSTOP);
    chk("scans", 16'h0003, 16'(nScan));
    chk("stopCause", 16'(dbg_pkg::CAUSE_NSCAN), 16'(stopCause));
    chk("outModules", 16'hA5A5, outModules);
    @(posedge clk);
    output_points <= 16'h5A5A;
    repeat (2) @(negedge clk);
    chk("outModules held", 16'hA5A5, outModules);
    chk("intPending", 16'h0001, 16'(intPending));
    $display("t_nscan done");
  endtask

  task automatic t_break_cond;
    @(posedge clk);
    scanCount <= 16'h0000;
    bpAddr <= 16'h0002;
    bpCount <= 16'h0002;
    cmd(1);
    wait_mode(dbg_pkg::MODE_DSTOP);
    chk("bp hits", 16'h0002, 16'(nHit));
    chk("stopCause", 16'(dbg_pkg::CAUSE_BREAK), 16'(stopCause));
    chk("traceRdData", 16'h0003, traceRdData);
    // or of one true term, then and of all four true terms
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk);
      bpCount <= 16'h0000;
      condEnable <= 1'b1;
      condOr <= (k == 1);
      condTerms <= (k == 1) ? 4'h2 : 4'hF;
      cmd(1);
      wait_mode(dbg_pkg::MODE_DSTOP);
      chk("cond scans", 16'h0001, 16'(nScan));
      chk("stopCause", 16'(dbg_pkg::CAUSE_COND), 16'(stopCause));
    end
    $display("t_break_cond done");
  endtask

  // loop and interrupt code never pause, nor call or taken target under rung step; two stepped scans tick
  task automatic t_flags;
    int nTick;
    @(posedge clk);
    condEnable <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      runFunc <= (k == 1 || k == 2) ? dbg_pkg::FN_RUNG : dbg_pkg::FN_STEP;
      inLoop <= (k == 0);
      inSubroutine <= (k == 1);
      takenTarget <= (k == 2);
      inInterrupt <= (k == 3);
      cmd(1);
      nTick = 0;
      repeat (8) begin
        @(negedge clk);
        if (timerStepTick === 1'b1)
          nTick++;
      end
      chk("modeId flagged", 16'(dbg_pkg::MODE_DRUN), 16'(modeId));
      chk("execEnable", 16'h0001, 16'(execEnable));
      chk("step ticks", 16'h0002, 16'(nTick));
      @(posedge clk);
      {inLoop, inSubroutine, takenTarget, inInterrupt} <= 4'h0;
      wait_mode(dbg_pkg::MODE_DSTOP);
      chk("stopCause",
          (k == 1 || k == 2) ? 16'(dbg_pkg::CAUSE_RUNG) : 16'(dbg_pkg::CAUSE_STEP),
          16'(stopCause));
    end
    $display("t_flags done");
  endtask

  task automatic t_exit;
    @(posedge clk);
    condEnable <= 1'b0;
    cmd(2);
    chk("modeId", 16'(dbg_pkg::MODE_HALT), 16'(modeId));
    chk("debugActive", 16'h0000, 16'(debugActive));
    cmd(0);
    chk("modeId reentry", 16'(dbg_pkg::MODE_DHALT), 16'(modeId));
    $display("t_exit done");
  endtask

  initial begin
    {rst, cmdEnter, cmdExit, cmdStart, startContinue, isolateIo} = 6'h20;
    {hostHalted, condEnable, condOr, condAtBreak} = 4'h0;
    {inLoop, inSubroutine, inInterrupt, takenTarget} = 4'h0;
    runFunc = 2'h0;
    condTerms = 4'h0;
    traceRdAddr = 4'h0;
    {bpCount, bpAddr, scanCount} = 48'h0;
    extInputs = 16'h1234;
    output_points = 16'h3C3C;
    n_fail = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_enter();
    t_step_iso();
    t_nscan();
    t_break_cond();
    t_flags();
    t_exit();
    finish_test();
  end
endmodule // program_debug_mode_controller_tb_top
